// ===== src/cell_rx_end.sv
// Receiving end of the cell link: training, polarity, cell checks, status.
// Assumes the link word on ref_clk; software uses the plain register port.
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module cell_rx_end
    import cell_link_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    cell_link_if.rx_end link,
    output logic rx_valid,
    output logic rx_sof,
    output logic rx_eof,
    output logic rx_frame_error_end_char,
    output logic [1:0] rx_vc,
    output logic [15:0] rx_data,
    output logic [3:0] channel_full_flags,
    output logic [3:0] channel_almost_full_flags,
    output logic [7:0] remote_user_byte,
    output logic [3:0] remote_version,
    output logic [1:0] remote_lanes,
    output logic remote_link_status,
    output logic link_up,
    output logic rx_polarity_invert,
    input wire logic [1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq
);
    logic [15:0] w;
    logic [1:0] c;
    logic is_hdr;
    logic is_end;
    logic is_data;
    logic train_ok;
    logic train_inv;
    logic train_next;
    logic in_cell;
    logic cell_empty;
    logic sof_pend;
    logic ser_bad;
    logic [1:0] cell_vc;
    logic [1:0] fill;
    logic [15:0] pend [3];
    logic [31:0] crc;
    logic [31:0] crc_fin;
    logic crc_ok;
    logic cell_bad;
    logic pop;
    logic last;
    serial_t expect_ser [4];
    logic [3:0] events;
    logic [3:0] status;
    logic [3:0] mask;

    assign w = link.link_data;
    assign c = link.link_ctrl;
    assign is_hdr = (c == `CTRL_HI) && (w[15:8] == `FRAME_START_CHAR
        || w[15:8] == `CELL_START_CHAR || w[15:8] == `EMPTY_START_CHAR);
    assign is_end = in_cell && (c == `CTRL_HI) && (w[15:8] == `CELL_END_CHAR
        || w[15:8] == `FRAME_END_CHAR || w[15:8] == `FRAME_ERROR_END_CHAR);
    assign is_data = in_cell && (c == `CTRL_NONE);
    assign train_ok = (c == `CTRL_LO) && (w == {`TRAIN_DATA_CHAR, `LINK_TRAINING_CHAR});
    assign train_inv = (c == `CTRL_LO) && (w == {`TRAIN_INV_CHAR, `LINK_TRAINING_CHAR});

    // ==========================================
    // Cell checks
    // The two words before the end char are the CRC, so payload leaves three words late
    assign pop = is_data && (fill == 2'h3);
    assign last = is_end && (fill == 2'h3);
    assign crc_fin = (fill == 2'h3) ? crc_step(crc, pend[2]) : crc;
    assign crc_ok = (fill >= 2'h2) && (crc_fin == {pend[1], pend[0]});
    assign cell_bad = !crc_ok || ser_bad;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            in_cell <= 1'b0;
            fill <= 2'h0;
            crc <= `CRC_INIT;
            cell_empty <= 1'b1;
            sof_pend <= 1'b0;
            cell_vc <= 2'h0;
            for (int i = 0; i < 3; i++) begin
                pend[i] <= 16'h0000;
            end
        end else if (is_hdr) begin
            in_cell <= 1'b1;
            fill <= 2'h0;
            crc <= crc_step(`CRC_INIT, w);
            cell_empty <= (w[15:8] == `EMPTY_START_CHAR);
            sof_pend <= (w[15:8] == `FRAME_START_CHAR);
            cell_vc <= w[`HDR_VC_MSB:`HDR_VC_LSB];
        end else if (is_end) begin
            in_cell <= 1'b0;
        end else if (is_data) begin
            pend[0] <= w;
            pend[1] <= pend[0];
            pend[2] <= pend[1];
            if (pop) begin
                crc <= crc_step(crc, pend[2]);
                sof_pend <= 1'b0;
            end else begin
                fill <= fill + 2'h1;
            end
        end
    end

    // Resync on every non-empty header so one lost cell is reported once
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ser_bad <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                expect_ser[i] <= 6'h00;
            end
        end else if (is_hdr && w[15:8] != `EMPTY_START_CHAR) begin
            ser_bad <= (w[`HDR_SER_MSB:`HDR_SER_LSB] != expect_ser[w[`HDR_VC_MSB:`HDR_VC_LSB]]);
            expect_ser[w[`HDR_VC_MSB:`HDR_VC_LSB]] <= w[`HDR_SER_MSB:`HDR_SER_LSB] + 6'h01;
        end else if (is_hdr) begin
            ser_bad <= 1'b0;
        end
    end

    // ==========================================
    // User stream, flags from good footers
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rx_valid <= 1'b0;
            rx_sof <= 1'b0;
            rx_eof <= 1'b0;
            rx_frame_error_end_char <= 1'b0;
            rx_vc <= 2'h0;
            rx_data <= 16'h0000;
        end else begin
            rx_valid <= (pop || last) && !cell_empty;
            rx_sof <= sof_pend;
            rx_vc <= cell_vc;
            rx_data <= pend[2];
            rx_eof <= last && !cell_bad && (w[15:8] == `FRAME_END_CHAR);
            rx_frame_error_end_char <= last && (cell_bad || w[15:8] == `FRAME_ERROR_END_CHAR);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            channel_full_flags <= 4'h0;
            channel_almost_full_flags <= 4'h0;
        end else if (is_end && crc_ok) begin
            channel_full_flags <= w[`FOOT_FULL_MSB:`FOOT_FULL_LSB];
            channel_almost_full_flags <= w[`FOOT_AFULL_MSB:`FOOT_AFULL_LSB];
        end
    end

    // ==========================================
    // Training set: link state, polarity, remote fields
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            link_up <= 1'b0;
            rx_polarity_invert <= 1'b0;
            train_next <= 1'b0;
        end else begin
            train_next <= train_ok;
            if (train_inv) begin
                rx_polarity_invert <= ~rx_polarity_invert;
                link_up <= 1'b0;
            end else if (train_ok) begin
                link_up <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            remote_user_byte <= 8'h00;
            remote_version <= 4'h0;
            remote_lanes <= 2'h0;
            remote_link_status <= 1'b0;
        end else if (train_next && c == `CTRL_NONE) begin
            remote_user_byte <= w[7:0];
            remote_version <= w[`TRAIN_VER_MSB:`TRAIN_VER_LSB];
            remote_lanes <= w[`TRAIN_LANE_MSB:`TRAIN_LANE_LSB];
            remote_link_status <= w[`TRAIN_LINK_BIT];
        end
    end

    // ==========================================
    // Status, mask, interrupt and register port
    assign events = {train_ok && !link_up, train_inv, is_end && ser_bad, is_end && !crc_ok};
    assign irq = |(status & mask);

    // A new event beats a write-one clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            status <= 4'h0;
            mask <= 4'h0;
        end else begin
            if (reg_wr && reg_addr == `REG_STATUS) begin
                status <= (status & ~reg_wdata[3:0]) | events;
            end else begin
                status <= status | events;
            end
            if (reg_wr && reg_addr == `REG_MASK) begin
                mask <= reg_wdata[3:0];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `REG_STATUS: reg_rdata <= {28'h0000000, status};
                `REG_MASK: reg_rdata <= {28'h0000000, mask};
                `REG_REMOTE: reg_rdata <= {17'h00000, remote_link_status, remote_lanes,
                    remote_version, remote_user_byte};
                default: reg_rdata <= {22'h000000, rx_polarity_invert, link_up,
                    channel_almost_full_flags, channel_full_flags};
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end
endmodule

// ===== common/cell_link_regs.svh
// Constants for the cell link: characters, field positions, counts, offsets.
// Assumes nothing; included by the package, the link checker and the bench.
`ifndef CELL_LINK_REGS_SVH
`define CELL_LINK_REGS_SVH
// ==========================================
// Characters (8b/10b byte values)
`define SKIP_CHAR 8'h1C
`define LINK_TRAINING_CHAR 8'h3C
`define COMMA_CHAR 8'hBC
`define ALIGN_CHAR 8'hDC
`define TRAIN_DATA_CHAR 8'h4A
`define TRAIN_INV_CHAR 8'hB5
`define FRAME_START_CHAR 8'hFB
`define CELL_START_CHAR 8'hF7
`define EMPTY_START_CHAR 8'h7C
`define CELL_END_CHAR 8'h5C
`define FRAME_END_CHAR 8'hFD
`define FRAME_ERROR_END_CHAR 8'hFE
// ==========================================
// Control flags per byte lane
`define CTRL_NONE 2'h0
`define CTRL_LO 2'h1
`define CTRL_HI 2'h2
`define CTRL_BOTH 2'h3
// ==========================================
// Field positions
`define TRAIN_LINK_BIT 15
`define TRAIN_SPARE_BIT 14
`define TRAIN_LANE_MSB 13
`define TRAIN_LANE_LSB 12
`define TRAIN_VER_MSB 11
`define TRAIN_VER_LSB 8
`define HDR_VC_MSB 7
`define HDR_VC_LSB 6
`define HDR_SER_MSB 5
`define HDR_SER_LSB 0
`define FOOT_FULL_MSB 7
`define FOOT_FULL_LSB 4
`define FOOT_AFULL_MSB 3
`define FOOT_AFULL_LSB 0
// ==========================================
// Counts and CRC
`define PAYLOAD_LIMIT_DEFAULT 3'h7
`define CRC_INIT 32'hFFFFFFFF
`define CRC_POLY 32'h04C11DB7
// ==========================================
// Receiver registers and status bits
`define REG_STATUS 2'h0
`define REG_MASK 2'h1
`define REG_REMOTE 2'h2
`define REG_LINK 2'h3
`define ST_CRC 0
`define ST_SERIAL 1
`define ST_POLARITY 2
`define ST_LINK_UP 3
`endif

// ===== common/cell_link_pkg.sv
// Types and the shared CRC step for both link ends.
// Assumes cell_link_regs.svh is on the include path.
`include "cell_link_regs.svh"
package cell_link_pkg;
    // Transmit sequencer, Gray coded along gap then cell
    typedef enum logic [3:0] {
        T_EMPTY = 4'h0,
        T_OS1A = 4'h1,
        T_OS1B = 4'h3,
        T_TRAINA = 4'h2,
        T_TRAINB = 4'h6,
        T_HDR = 4'h7,
        T_PAY = 4'h5,
        T_CRCH = 4'h4,
        T_CRCL = 4'hC,
        T_FOOT = 4'hD
    } tx_state_t;

    typedef logic [5:0] serial_t;

    // MSB-first CRC-32 over one 16-bit word
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [15:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 15; i >= 0; i--) begin
            if (r[31] ^ d[i]) begin
                r = {r[30:0], 1'b0} ^ `CRC_POLY;
            end else begin
                r = {r[30:0], 1'b0};
            end
        end
        return r;
    endfunction
endpackage

// ===== common/cell_link_if.sv
// One direction of the serial link, seen after 8b/10b decode.
// Assumes both ends share ref_clk; the bench joins the two modports.
`timescale 1ns/100ps
interface cell_link_if;
    logic [15:0] link_data;
    logic [1:0] link_ctrl;
    modport tx_end (output link_data, output link_ctrl);
    modport rx_end (input link_data, input link_ctrl);
endinterface

// ===== src/cell_tx_end.sv
// Transmitting end of the cell link: gap ordered sets, cells, empty cells.
// Assumes a 40 MHz ref_clk, the decoded link word and a same-clock user side.
// What this block does
// - Gap: empty clock, then two ordered sets
// - Sets two clocks, gap one, cell overhead four
// - Payload length from limit, default 256 words
// - Training set: K28.1 then D10.2, D21.5 inverted
// - Receiver uses training set for link, polarity
// - Training set carries byte, version, lanes, spare, status
// - Training set sent in every gap
// - Align set: K28.6/K28.5 then K28.6 twice
// - Skip set: K28.0/K28.5 then K28.0 twice
// - Skip and align sets alternate cell by cell
// - Header: frame or cell start, channel, serial
// - Per-channel serial counters; receiver finds lost cells
// - Footer CRC-32 over header and payload, checked
// - Footer carries full and almost-full per channel
// - End char: cell end, frame end, error end
// - No data ready: send an empty cell
`timescale 1ns/100ps
module cell_tx_end
    import cell_link_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    cell_link_if.tx_end link,
    input wire logic [2:0] payload_count_limit,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic tx_sof,
    input wire logic tx_eof,
    input wire logic tx_frame_error_end_char,
    input wire logic [1:0] tx_vc,
    input wire logic [15:0] tx_data,
    input wire logic [3:0] loc_full,
    input wire logic [3:0] loc_afull,
    input wire logic [7:0] loc_user_byte,
    input wire logic [3:0] endpoint_version,
    input wire logic [1:0] lane_count_field,
    input wire logic remote_link_ok,
    output logic cell_done
);
    tx_state_t state;
    tx_state_t next_state;
    logic [15:0] next_word;
    logic [1:0] next_ctrl;
    logic [15:0] hdr_word;
    logic [8:0] cell_len;
    logic [8:0] word_cnt;
    logic [31:0] crc;
    logic [1:0] cell_vc;
    logic [7:0] end_char;
    logic comp_turn;
    logic take;
    logic last_take;
    serial_t serial [4];

    // ==========================================
    // Payload handshake
    // Cell length is 2^(limit+1) words; the default limit gives 256
    assign cell_len = 9'h001 << (4'(payload_count_limit) + 4'h1);
    // A channel change closes the cell so one cell never mixes channels
    assign tx_ready = (state == T_PAY) && (tx_vc == cell_vc);
    assign take = tx_ready && tx_valid;
    assign last_take = take && (tx_eof || tx_frame_error_end_char || word_cnt == cell_len - 9'h001);

    always_comb begin
        if (tx_valid) begin
            hdr_word = {tx_sof ? `FRAME_START_CHAR : `CELL_START_CHAR, tx_vc, serial[tx_vc]};
        end else begin
            hdr_word = {`EMPTY_START_CHAR, 8'h00};
        end
    end

    // ==========================================
    // Sequencer and next link word
    always_comb begin
        next_state = state;
        next_word = 16'h0000;
        next_ctrl = `CTRL_NONE;
        case (state)
            T_EMPTY: begin
                next_state = T_OS1A;
            end
            T_OS1A: begin
                next_ctrl = `CTRL_BOTH;
                if (comp_turn) begin
                    next_word = {`SKIP_CHAR, `COMMA_CHAR};
                end else begin
                    next_word = {`ALIGN_CHAR, `COMMA_CHAR};
                end
                next_state = T_OS1B;
            end
            T_OS1B: begin
                next_ctrl = `CTRL_BOTH;
                if (comp_turn) begin
                    next_word = {`SKIP_CHAR, `SKIP_CHAR};
                end else begin
                    next_word = {`ALIGN_CHAR, `ALIGN_CHAR};
                end
                next_state = T_TRAINA;
            end
            T_TRAINA: begin
                next_ctrl = `CTRL_LO;
                next_word = {`TRAIN_DATA_CHAR, `LINK_TRAINING_CHAR};
                next_state = T_TRAINB;
            end
            T_TRAINB: begin
                next_word[`TRAIN_LINK_BIT] = remote_link_ok;
                next_word[`TRAIN_SPARE_BIT] = 1'b0;
                next_word[`TRAIN_LANE_MSB:`TRAIN_LANE_LSB] = lane_count_field;
                next_word[`TRAIN_VER_MSB:`TRAIN_VER_LSB] = endpoint_version;
                next_word[7:0] = loc_user_byte;
                next_state = T_HDR;
            end
            T_HDR: begin
                next_ctrl = `CTRL_HI;
                next_word = hdr_word;
                next_state = tx_valid ? T_PAY : T_CRCH;
            end
            T_PAY: begin
                if (take) begin
                    next_word = tx_data;
                    next_state = last_take ? T_CRCH : T_PAY;
                end else begin
                    // Data ran dry: close the cell now, the link never idles mid-cell
                    next_word = crc[31:16];
                    next_state = T_CRCL;
                end
            end
            T_CRCH: begin
                next_word = crc[31:16];
                next_state = T_CRCL;
            end
            T_CRCL: begin
                next_word = crc[15:0];
                next_state = T_FOOT;
            end
            T_FOOT: begin
                next_ctrl = `CTRL_HI;
                next_word = {end_char, loc_full, loc_afull};
                next_state = T_EMPTY;
            end
            default: begin
                next_state = T_EMPTY;
            end
        endcase
    end

    // ==========================================
    // Registers
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state <= T_EMPTY;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            link.link_data <= 16'h0000;
            link.link_ctrl <= `CTRL_NONE;
            cell_done <= 1'b0;
        end else begin
            link.link_data <= next_word;
            link.link_ctrl <= next_ctrl;
            cell_done <= (state == T_FOOT);
        end
    end

    // Skip set after every other cell, align set after the rest
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            comp_turn <= 1'b1;
        end else if (state == T_OS1B) begin
            comp_turn <= ~comp_turn;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            crc <= `CRC_INIT;
        end else if (state == T_HDR) begin
            crc <= crc_step(`CRC_INIT, hdr_word);
        end else if (take) begin
            crc <= crc_step(crc, tx_data);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            word_cnt <= 9'h000;
            cell_vc <= 2'h0;
        end else if (state == T_HDR) begin
            word_cnt <= 9'h000;
            cell_vc <= tx_vc;
        end else if (take) begin
            word_cnt <= word_cnt + 9'h001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            end_char <= `CELL_END_CHAR;
        end else if (state == T_HDR) begin
            end_char <= `CELL_END_CHAR;
        end else if (take && tx_frame_error_end_char) begin
            end_char <= `FRAME_ERROR_END_CHAR;
        end else if (take && tx_eof) begin
            end_char <= `FRAME_END_CHAR;
        end
    end

    // Empty cells leave the serial numbers alone
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            for (int i = 0; i < 4; i++) begin
                serial[i] <= 6'h00;
            end
        end else if (state == T_HDR && tx_valid) begin
            serial[tx_vc] <= serial[tx_vc] + 6'h01;
        end
    end
endmodule

// ===== sim/cell_link_props.sv
// Link word checks between the two cell link ends.
// Assumes the decoded link word and ref_clk with reset_n from the bench.
`timescale 1ns/100ps
`include "cell_link_regs.svh"
module cell_link_props (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [15:0] link_data,
    input wire logic [1:0] link_ctrl
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // ==========================================
    // Word classes
    logic os1, hdr, foot, last_skip;
    assign os1 = link_ctrl == `CTRL_BOTH && link_data[7:0] == `COMMA_CHAR;
    assign hdr = link_ctrl == `CTRL_HI && link_data[15:8] inside
        {`FRAME_START_CHAR, `CELL_START_CHAR, `EMPTY_START_CHAR};
    assign foot = link_ctrl == `CTRL_HI && link_data[15:8] inside
        {`CELL_END_CHAR, `FRAME_END_CHAR, `FRAME_ERROR_END_CHAR};
    // Cleared to align so the first gap after reset must use the skip set
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            last_skip <= 1'b0;
        end else if (os1) begin
            last_skip <= link_data[15:8] == `SKIP_CHAR;
        end
    end
    // ==========================================
    // Gap and cell framing
    a_gap_empty: assert property (os1 |-> $past(link_data) == 16'h0000
        && $past(link_ctrl) == `CTRL_NONE) else $error("set without empty clock");
    a_skip_set: assert property (os1 && link_data[15:8] == `SKIP_CHAR |=>
        link_data == {`SKIP_CHAR, `SKIP_CHAR} && link_ctrl == `CTRL_BOTH)
        else $error("bad skip set");
    a_align_set: assert property (os1 && link_data[15:8] == `ALIGN_CHAR |=>
        link_data == {`ALIGN_CHAR, `ALIGN_CHAR} && link_ctrl == `CTRL_BOTH)
        else $error("bad align set");
    a_train_word: assert property (os1 |=> ##1
        link_data == {`TRAIN_DATA_CHAR, `LINK_TRAINING_CHAR} && link_ctrl == `CTRL_LO)
        else $error("training set missing");
    a_train_hdr: assert property (os1 |=> ##2 link_ctrl == `CTRL_NONE ##1 hdr)
        else $error("header not after training");
    a_gap_after: assert property (foot |=> link_data == 16'h0000
        && link_ctrl == `CTRL_NONE ##1 os1) else $error("gap not after footer");
    a_os_alternate: assert property (os1 |->
        (link_data[15:8] == `SKIP_CHAR) != last_skip) else $error("sets not alternating");
    a_empty_cell: assert property (hdr && link_data[15:8] == `EMPTY_START_CHAR |->
        link_data[7:0] == 8'h00 ##1 link_ctrl == `CTRL_NONE [*2] ##1 foot)
        else $error("bad empty cell");
endmodule

// ===== sim/cell_link_framer_tb.sv
// Bench for the cell link: transmitter and receiver joined by one interface.
// Assumes design, interface and checker files are compiled before it.
`timescale 1ns/100ps
`include "cell_link_regs.svh"
module cell_link_framer_tb;
    logic ref_clk = 0, reset_n = 0, tx_valid = 0, tx_sof = 0, tx_eof = 0, tx_frame_error_end_char = 0;
    logic reg_wr = 0, reg_rd = 0, irq, rx_valid, rx_sof, rx_eof, rx_frame_error_end_char, pol_b, done;
    logic [2:0] limit = 3'h7;
    logic [1:0] tx_vc = 2'h0, reg_addr = 2'h0, rx_vc;
    logic [15:0] tx_data = 16'h0000, rx_data;
    logic [3:0] lf = 4'hA, full;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rdata_b, got, got_b;
    logic [31:0] rxq[$];
    logic [17:0] bad[8] = '{18'h14A3C, 18'h0, 18'h2FB41, 18'h01234, 18'h0, 18'h0,
        18'h2FD00, 18'h1B53C};
    int miscompares = 0, tests_run = 0, cells = 0;
    cell_link_if link();
    cell_link_if bad_link();
    cell_tx_end i_cell_tx_end (.ref_clk(ref_clk), .reset_n(reset_n), .link(link),
        .payload_count_limit(limit), .tx_valid(tx_valid), .tx_ready(), .tx_sof(tx_sof),
        .tx_eof(tx_eof), .tx_frame_error_end_char(tx_frame_error_end_char), .tx_vc(tx_vc), .tx_data(tx_data),
        .loc_full(lf), .loc_afull(4'h5), .loc_user_byte(8'h5A), .endpoint_version(4'h3),
        .lane_count_field(2'h1), .remote_link_ok(1'b1), .cell_done(done));
    cell_rx_end i_cell_rx_end (.ref_clk(ref_clk), .reset_n(reset_n), .link(link),
        .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_frame_error_end_char(rx_frame_error_end_char),
        .rx_vc(rx_vc), .rx_data(rx_data), .channel_full_flags(full),
        .channel_almost_full_flags(), .remote_user_byte(), .remote_version(),
        .remote_lanes(), .remote_link_status(), .link_up(), .rx_polarity_invert(),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq));
    // Second receiver fed hand-built faulty link words from the bad table
    cell_rx_end i_cell_rx_end_b (.ref_clk(ref_clk), .reset_n(reset_n), .link(bad_link),
        .rx_valid(), .rx_sof(), .rx_eof(), .rx_frame_error_end_char(), .rx_vc(), .rx_data(),
        .channel_full_flags(), .channel_almost_full_flags(), .remote_user_byte(),
        .remote_version(), .remote_lanes(), .remote_link_status(), .link_up(),
        .rx_polarity_invert(pol_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_b), .irq());
    cell_link_props i_cell_link_props (.ref_clk(ref_clk), .reset_n(reset_n),
        .link_data(link.link_data), .link_ctrl(link.link_ctrl));
    // ==========================================
    // Clock, monitors, tasks
    initial forever #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (rx_valid === 1'b1) begin
            rxq.push_back({11'h0, rx_vc, rx_sof, rx_eof, rx_frame_error_end_char, rx_data});
        end
        if (link.link_ctrl === `CTRL_HI && link.link_data[15:8] inside
            {`FRAME_START_CHAR, `CELL_START_CHAR}) begin
            cells++;
        end
        // Cell done pulses with the footer word, never elsewhere
        if (reset_n) begin
            chk("done", link.link_ctrl === `CTRL_HI && link.link_data[15:8] inside
                {`CELL_END_CHAR, `FRAME_END_CHAR, `FRAME_ERROR_END_CHAR}, done);
        end
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [1:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [1:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        got = reg_rdata;
        got_b = rdata_b;
    endtask
    // Holds valid through the gaps so a long frame spans cells without stalling
    task frame(input logic [1:0] vc, input int n, input logic err, input int nc);
        int i, k;
        logic rdy;
        i = 0;
        cells = 0;
        @(posedge ref_clk);
        tx_vc <= vc;
        tx_valid <= 1'b1;
        tx_sof <= 1'b1;
        tx_data <= 16'h1000;
        tx_eof <= n == 1 && !err;
        tx_frame_error_end_char <= n == 1 && err;
        while (i < n) begin
            @(negedge ref_clk);
            rdy = i_cell_tx_end.tx_ready;
            @(posedge ref_clk);
            if (rdy === 1'b1) begin
                i++;
                tx_sof <= 1'b0;
                tx_data <= 16'h1000 + i[15:0];
                tx_eof <= i == n - 1 && !err;
                tx_frame_error_end_char <= i == n - 1 && err;
            end
        end
        tx_valid <= 1'b0;
        for (k = 0; k < 600 && rxq.size() < n; k++) @(posedge ref_clk);
        chk("words", n, rxq.size());
        chk("cells", nc, cells);
        for (k = 0; k < n && k < rxq.size(); k++) begin
            chk("word", {11'h0, vc, k == 0, k == n - 1 && !err, k == n - 1 && err,
                16'h1000 + k[15:0]}, rxq[k]);
        end
        rxq.delete();
    endtask
    task results;
        $display("tests %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ==========================================
    // Tests
    initial begin
        repeat (5000) @(posedge ref_clk);
        miscompares++;
        results();
    end
    initial begin
        bad_link.link_data = 16'h0000;
        bad_link.link_ctrl = `CTRL_NONE;
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (30) @(posedge ref_clk);
        rd(`REG_LINK);
        chk("link", 32'h15A, got);
        rd(`REG_REMOTE);
        chk("remote", 32'h535A, got);
        wr(`REG_REMOTE, 32'h0);
        rd(`REG_STATUS);
        chk("status", 32'h8, got);
        rd(`REG_REMOTE);
        chk("remote kept", 32'h535A, got);
        wr(`REG_MASK, 32'h8);
        @(negedge ref_clk);
        chk("irq on", 1, irq);
        wr(`REG_STATUS, 32'h8);
        @(negedge ref_clk);
        chk("irq off", 0, irq);
        $display("test link done");
        @(posedge ref_clk);
        lf <= 4'h3;
        frame(2'h1, 3, 1'b0, 1);
        frame(2'h2, 2, 1'b1, 1);
        chk("full", 4'h3, full);
        limit <= 3'h0;
        frame(2'h3, 5, 1'b0, 3);
        frame(2'h3, 5, 1'b0, 3);
        rd(`REG_STATUS);
        chk("no errors", 32'h0, got);
        $display("test frames done");
        foreach (bad[j]) begin
            @(posedge ref_clk);
            {bad_link.link_ctrl, bad_link.link_data} <= bad[j];
        end
        @(posedge ref_clk);
        {bad_link.link_ctrl, bad_link.link_data} <= 18'h0;
        repeat (4) @(posedge ref_clk);
        chk("invert", 1, pol_b);
        rd(`REG_STATUS);
        chk("bad status", 32'hF, got_b);
        $display("test faults done");
        results();
    end
endmodule
